// ===== design/feature_ctrl_pkg.sv
// constants and register map of the feature-control register bank
// Behaviour
// - legacy view of feature register equals its low 32 bits.
// - bits 0-10 and 18 read/write; other positions reserved, written zero.
// - bit 0 set enables virtualized maskable interrupts via flag and pending.
// - bit 0 set enables bitmap-driven software-interrupt interception.
// - bit 1 set enables virtual interrupt flag and pending support.
// - bit 1 affects only set/clear interrupt-flag instructions, no bitmap.
// - bit 1 honoured in long mode as in legacy protected mode.
// - bit 2 set allows timestamp reads only at privilege level 0.
// - bit 3 set enables I/O breakpoints; debug regs 4/5 raise invalid opcode.
// - bit 3 clear disables I/O breakpoints; regs 4/5 alias to 6/7.
// - bit 4 set permits large pages selected by directory page-size field.
// - bit 4 clear with bit 5 clear restricts all pages to small size, rejects large use.
// - bit 4 ignored while physical-address extension is on, so long mode.
// - table base register points to top-level translation table.
// - fault address and table base serve only page translation.
// - bit 5 enables extended physical addressing and 2-Mbyte pages.
// - in 64-bit mode writing one to an upper bit raises protection fault.
package feature_ctrl_pkg;
    localparam logic [7:0] OFS_FC_LO = 8'h00;
    localparam logic [7:0] OFS_FC_HI = 8'h04;
    localparam logic [7:0] OFS_FA_LO = 8'h08;
    localparam logic [7:0] OFS_FA_HI = 8'h0C;
    localparam logic [7:0] OFS_TB_LO = 8'h10;
    localparam logic [7:0] OFS_TB_HI = 8'h14;
    localparam logic [7:0] OFS_MODE = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

    localparam int BIT_V86 = 0;
    localparam int BIT_PVI = 1;
    localparam int BIT_TSR = 2;
    localparam int BIT_DBG = 3;
    localparam int BIT_LPG = 4;
    localparam int BIT_PAE = 5;
    localparam int BIT_MCE = 6;
    localparam int BIT_GPG = 7;
    localparam int BIT_PCU = 8;
    localparam int BIT_FXS = 9;
    localparam int BIT_SFE = 10;
    localparam int BIT_XSV = 18;

    localparam logic [31:0] FC_RW_MASK = 32'h0004_07FF;
    localparam logic [31:0] FC_RESET = 32'h0000_0000;
    localparam logic [63:0] ADDR_RESET = 64'h0000_0000_0000_0000;

    localparam int MODE_LONG = 0;
    localparam int MODE_CODE64 = 1;
    localparam int MODE_V86 = 2;
    localparam logic [31:0] MODE_MASK = 32'h0000_0007;

    localparam int EV_GP = 0;
    localparam int EV_UD = 1;
    localparam int EV_TS = 2;
    localparam int EV_PF = 3;
    localparam int EV_W = 4;

    localparam logic [2:0] DBG_REG_4 = 3'h4;
    localparam logic [2:0] DBG_REG_5 = 3'h5;
    localparam logic [2:0] DBG_REG_6 = 3'h6;
    localparam logic [2:0] DBG_REG_7 = 3'h7;
    localparam logic [1:0] CPL_KERNEL = 2'h0;
endpackage : feature_ctrl_pkg

// ===== design/byte_merge.sv
// byte-lane write merge for one 32-bit register word
module byte_merge
    import feature_ctrl_pkg::*;
(
    input wire logic [31:0] old_val,
    input wire logic [31:0] wr_val,
    input wire logic [3:0] be,
    input wire logic [31:0] keep_mask,
    output logic [31:0] new_val
);
    logic [31:0] merged;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign merged[g*8 +: 8] = be[g] ? wr_val[g*8 +: 8]
                                            : old_val[g*8 +: 8];
        end
    endgenerate

    // unimplemented positions are forced to zero on every write
    assign new_val = merged & keep_mask;
endmodule : byte_merge

// ===== design/feature_policy.sv
// combinational decode of feature enables into consumer decisions
module feature_policy
    import feature_ctrl_pkg::*;
(
    input wire logic [31:0] fc,
    input wire logic v86_mode,
    input wire logic [1:0] cpl,
    input wire logic [2:0] dbg_reg_num,
    input wire logic pde_page_size,
    input wire logic redir_bitmap_bit,
    output logic v86_virt_int,
    output logic swint_redirect,
    output logic pm_virt_sti_cli,
    output logic ts_allow,
    output logic io_bp_enable,
    output logic dbg_ud,
    output logic [2:0] dbg_target,
    output logic large_page_sel,
    output logic large_page_reject
);
    logic dbg_45;
    logic big_ok;

    assign v86_virt_int = fc[BIT_V86] & v86_mode;
    assign swint_redirect = fc[BIT_V86] & v86_mode & ~redir_bitmap_bit;
    assign pm_virt_sti_cli = fc[BIT_PVI] & ~v86_mode;
    assign ts_allow = ~fc[BIT_TSR] | (cpl == CPL_KERNEL);
    assign dbg_45 = (dbg_reg_num == DBG_REG_4) | (dbg_reg_num == DBG_REG_5);
    assign io_bp_enable = fc[BIT_DBG];
    assign dbg_ud = fc[BIT_DBG] & dbg_45;
    assign dbg_target = (~fc[BIT_DBG] & (dbg_reg_num == DBG_REG_4)) ? DBG_REG_6
                      : (~fc[BIT_DBG] & (dbg_reg_num == DBG_REG_5)) ? DBG_REG_7
                      : dbg_reg_num;
    assign big_ok = fc[BIT_PAE] | fc[BIT_LPG];
    assign large_page_sel = pde_page_size & big_ok;
    assign large_page_reject = pde_page_size & ~big_ok;
endmodule : feature_policy

// ===== design/paging_feature_control_regs.sv
// feature-control, fault-address and table-base registers on avalon-mm
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
module paging_feature_control_regs
    import feature_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    output logic v86_ext_enable,
    output logic pm_virt_int_enable,
    output logic timestamp_priv_restrict,
    output logic debug_ext_enable,
    output logic large_page_enable,
    output logic phys_addr_ext_enable,
    output logic machine_check_enable,
    output logic global_page_enable,
    output logic perf_counter_user_enable,
    output logic fx_save_restore_enable,
    output logic simd_fp_exc_enable,
    output logic ext_state_save_enable,
    output logic [63:0] fault_address,
    output logic [63:0] table_base,
    input wire logic pf_valid,
    input wire logic [63:0] pf_addr,
    input wire logic [1:0] cpl,
    input wire logic ts_read_req,
    output logic ts_allow,
    input wire logic dbg_access,
    input wire logic [2:0] dbg_reg_num,
    output logic dbg_ud,
    output logic [2:0] dbg_target,
    output logic io_bp_enable,
    input wire logic pde_page_size,
    output logic large_page_sel,
    output logic large_page_reject,
    input wire logic redir_bitmap_bit,
    output logic v86_virt_int,
    output logic swint_redirect,
    output logic pm_virt_sti_cli
);
    logic [31:0] fc_r;
    logic [63:0] fa_r;
    logic [63:0] tb_r;
    logic [31:0] mode_r;
    logic [EV_W-1:0] stat_r;
    logic [EV_W-1:0] stat_nxt;
    logic [EV_W-1:0] mask_r;
    logic [EV_W-1:0] ev;
    logic [31:0] readdata_r;
    logic ack_r;
    logic req;
    logic wr_fire;
    logic rd_fire;
    logic [31:0] rd_mux;
    logic [31:0] fc_nxt;
    logic [31:0] mode_nxt;
    logic [31:0] fa_lo_nxt;
    logic [31:0] fa_hi_nxt;
    logic [31:0] tb_lo_nxt;
    logic [31:0] tb_hi_nxt;
    logic [31:0] hi_written;
    logic in_64bit;
    logic ev_gp;

    // one wait cycle gives a registered read word and a clean write edge
    assign req = read | write;
    assign waitrequest = req & ~ack_r;
    assign wr_fire = write & ack_r;
    assign rd_fire = read & ack_r;
    assign readdata = readdata_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    byte_merge u_fc_merge (
        .old_val(fc_r),
        .wr_val(writedata),
        .be(byteenable),
        .keep_mask(FC_RW_MASK),
        .new_val(fc_nxt)
    );

    byte_merge u_hi_merge (
        .old_val(32'h0000_0000),
        .wr_val(writedata),
        .be(byteenable),
        .keep_mask(32'hFFFF_FFFF),
        .new_val(hi_written)
    );

    byte_merge u_mode_merge (
        .old_val(mode_r),
        .wr_val(writedata),
        .be(byteenable),
        .keep_mask(MODE_MASK),
        .new_val(mode_nxt)
    );

    byte_merge u_fa_lo (
        .old_val(fa_r[31:0]),
        .wr_val(writedata),
        .be(byteenable),
        .keep_mask(32'hFFFF_FFFF),
        .new_val(fa_lo_nxt)
    );

    byte_merge u_fa_hi (
        .old_val(fa_r[63:32]),
        .wr_val(writedata),
        .be(byteenable),
        .keep_mask(32'hFFFF_FFFF),
        .new_val(fa_hi_nxt)
    );

    byte_merge u_tb_lo (
        .old_val(tb_r[31:0]),
        .wr_val(writedata),
        .be(byteenable),
        .keep_mask(32'hFFFF_FFFF),
        .new_val(tb_lo_nxt)
    );

    byte_merge u_tb_hi (
        .old_val(tb_r[63:32]),
        .wr_val(writedata),
        .be(byteenable),
        .keep_mask(32'hFFFF_FFFF),
        .new_val(tb_hi_nxt)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            fc_r <= FC_RESET;
        end else if (wr_fire && address == OFS_FC_LO) begin
            fc_r <= fc_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r <= 32'h0000_0000;
        end else if (wr_fire && address == OFS_MODE) begin
            mode_r <= mode_nxt;
        end
    end

    // fault address only captured by the walker or software
    always_ff @(posedge clk) begin
        if (rst) begin
            fa_r <= ADDR_RESET;
        end else if (pf_valid) begin
            fa_r <= pf_addr;
        end else if (wr_fire && address == OFS_FA_LO) begin
            fa_r[31:0] <= fa_lo_nxt;
        end else if (wr_fire && address == OFS_FA_HI) begin
            fa_r[63:32] <= fa_hi_nxt;
        end
    end

    // table base feeds the walker only
    always_ff @(posedge clk) begin
        if (rst) begin
            tb_r <= ADDR_RESET;
        end else if (wr_fire && address == OFS_TB_LO) begin
            tb_r[31:0] <= tb_lo_nxt;
        end else if (wr_fire && address == OFS_TB_HI) begin
            tb_r[63:32] <= tb_hi_nxt;
        end
    end

    assign in_64bit = mode_r[MODE_LONG] & mode_r[MODE_CODE64];
    // nonzero upper-half write in 64-bit mode faults
    assign ev_gp = wr_fire & (address == OFS_FC_HI) & in_64bit
                 & (hi_written != 32'h0000_0000);

    always_comb begin
        ev = '0;
        ev[EV_GP] = ev_gp;
        ev[EV_UD] = dbg_access & dbg_ud;
        ev[EV_TS] = ts_read_req & ~ts_allow;
        ev[EV_PF] = pf_valid;
    end

    // new events win over the clear-on-read
    always_comb begin
        stat_nxt = stat_r;
        if (rd_fire && address == OFS_IRQ_STAT) begin
            stat_nxt = '0;
        end
        stat_nxt = stat_nxt | ev;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stat_r <= '0;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask_r <= '0;
        end else if (wr_fire && address == OFS_IRQ_MASK) begin
            mask_r <= writedata[EV_W-1:0];
        end
    end

    assign irq = |(stat_r & mask_r);

    // upper half always reads zero, legacy view is the low word
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (address == OFS_FC_LO) begin
            rd_mux = fc_r;
        end else if (address == OFS_FC_HI) begin
            rd_mux = 32'h0000_0000;
        end else if (address == OFS_FA_LO) begin
            rd_mux = fa_r[31:0];
        end else if (address == OFS_FA_HI) begin
            rd_mux = fa_r[63:32];
        end else if (address == OFS_TB_LO) begin
            rd_mux = tb_r[31:0];
        end else if (address == OFS_TB_HI) begin
            rd_mux = tb_r[63:32];
        end else if (address == OFS_MODE) begin
            rd_mux = mode_r;
        end else if (address == OFS_IRQ_STAT) begin
            rd_mux = {{(32-EV_W){1'b0}}, stat_r};
        end else if (address == OFS_IRQ_MASK) begin
            rd_mux = {{(32-EV_W){1'b0}}, mask_r};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            readdata_r <= 32'h0000_0000;
        end else if (read && !ack_r) begin
            readdata_r <= rd_mux;
        end
    end

    assign v86_ext_enable = fc_r[BIT_V86];
    assign pm_virt_int_enable = fc_r[BIT_PVI];
    assign timestamp_priv_restrict = fc_r[BIT_TSR];
    assign debug_ext_enable = fc_r[BIT_DBG];
    // large-page enable is masked while address extension is on
    assign large_page_enable = fc_r[BIT_LPG] & ~fc_r[BIT_PAE];
    assign phys_addr_ext_enable = fc_r[BIT_PAE];
    assign machine_check_enable = fc_r[BIT_MCE];
    assign global_page_enable = fc_r[BIT_GPG];
    assign perf_counter_user_enable = fc_r[BIT_PCU];
    assign fx_save_restore_enable = fc_r[BIT_FXS];
    assign simd_fp_exc_enable = fc_r[BIT_SFE];
    assign ext_state_save_enable = fc_r[BIT_XSV];
    assign fault_address = fa_r;
    assign table_base = tb_r;

    feature_policy u_policy (
        .fc(fc_r),
        .v86_mode(mode_r[MODE_V86]),
        .cpl(cpl),
        .dbg_reg_num(dbg_reg_num),
        .pde_page_size(pde_page_size),
        .redir_bitmap_bit(redir_bitmap_bit),
        .v86_virt_int(v86_virt_int),
        .swint_redirect(swint_redirect),
        .pm_virt_sti_cli(pm_virt_sti_cli),
        .ts_allow(ts_allow),
        .io_bp_enable(io_bp_enable),
        .dbg_ud(dbg_ud),
        .dbg_target(dbg_target),
        .large_page_sel(large_page_sel),
        .large_page_reject(large_page_reject)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_RSVD_ZERO: assert property (
        (fc_r & ~FC_RW_MASK) == 32'h0000_0000)
        else $error("reserved feature bit set");

    AST_HI_READ_ZERO: assert property (
        (read && !ack_r && address == OFS_FC_HI) |=> readdata == 32'h0)
        else $error("upper half read not zero");

    AST_FC_WRITE: assert property (
        (wr_fire && address == OFS_FC_LO && byteenable == 4'hF)
        |=> fc_r == (($past(writedata)) & FC_RW_MASK))
        else $error("feature write not stored masked");

    AST_GP_EVENT: assert property (
        ev_gp |=> stat_r[EV_GP] && $stable(fc_r))
        else $error("upper write fault not flagged");

    AST_TS_GATE: assert property (
        (fc_r[BIT_TSR] && cpl != CPL_KERNEL) |-> !ts_allow)
        else $error("timestamp allowed above level 0");

    AST_DBG_ALIAS: assert property (
        (!fc_r[BIT_DBG] && dbg_reg_num == DBG_REG_5)
        |-> dbg_target == DBG_REG_7 && !dbg_ud)
        else $error("debug reg 5 not aliased");

    AST_DBG_UD: assert property (
        (dbg_access && fc_r[BIT_DBG] && dbg_reg_num == DBG_REG_4)
        |=> stat_r[EV_UD])
        else $error("debug reg 4 access not trapped");

    AST_PAGE_SMALL: assert property (
        (!fc_r[BIT_LPG] && !fc_r[BIT_PAE] && pde_page_size)
        |-> large_page_reject && !large_page_sel)
        else $error("large page not rejected");

    AST_PAE_OVERRIDE: assert property (
        fc_r[BIT_PAE] |-> !large_page_enable && !large_page_reject)
        else $error("page-size bit not ignored under extension");

    AST_SWINT: assert property (
        (!fc_r[BIT_V86]) |-> !swint_redirect)
        else $error("interception without v86 enable");

    AST_WAIT_ONE: assert property (
        (req && !ack_r) |=> !waitrequest || !req)
        else $error("waitrequest held beyond one cycle");

    AST_IRQ_LEVEL: assert property (
        (stat_r[EV_PF] && mask_r[EV_PF]) |-> irq)
        else $error("unmasked status without interrupt");

    COV_GP: cover property (ev_gp ##1 irq);
    COV_UD: cover property (dbg_access && dbg_ud);
    COV_LARGE: cover property (large_page_sel && fc_r[BIT_LPG]);
    COV_STAT_CLR: cover property (
        rd_fire && address == OFS_IRQ_STAT && stat_r != '0);
endmodule : paging_feature_control_regs

// ===== sim/paging_feature_control_regs_test.sv
// self-checking bench for the feature-control register bank
module paging_feature_control_regs_test
    import feature_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'h0;
    logic pf_valid = 1'b0;
    logic [63:0] pf_addr = 64'h0000_0000_0000_0000;
    logic [1:0] cpl = 2'h0;
    logic ts_read_req = 1'b0;
    logic dbg_access = 1'b0;
    logic [2:0] dbg_reg_num = 3'h0;
    logic pde_page_size = 1'b0;
    logic redir_bitmap_bit = 1'b0;
    logic [31:0] readdata;
    logic waitrequest, irq, v86_ext_enable, pm_virt_int_enable;
    logic timestamp_priv_restrict, debug_ext_enable, large_page_enable;
    logic phys_addr_ext_enable, machine_check_enable, global_page_enable;
    logic perf_counter_user_enable, fx_save_restore_enable;
    logic simd_fp_exc_enable, ext_state_save_enable, ts_allow, dbg_ud;
    logic io_bp_enable, large_page_sel, large_page_reject, v86_virt_int;
    logic swint_redirect, pm_virt_sti_cli;
    logic [63:0] fault_address, table_base;
    logic [2:0] dbg_target;
    logic [31:0] exp_q[$];
    logic [31:0] fc_m = 32'h0000_0000;
    logic [31:0] rnd = 32'h0000_94C9;
    logic [63:0] a64;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] regs[9] = '{OFS_FC_LO, OFS_FC_HI, OFS_FA_LO, OFS_FA_HI,
        OFS_TB_LO, OFS_TB_HI, OFS_MODE, OFS_IRQ_STAT, OFS_IRQ_MASK};

    paging_feature_control_regs i_dut (.clk, .rst, .address, .read, .write,
        .writedata, .byteenable, .readdata, .waitrequest, .irq,
        .v86_ext_enable, .pm_virt_int_enable, .timestamp_priv_restrict,
        .debug_ext_enable, .large_page_enable, .phys_addr_ext_enable,
        .machine_check_enable, .global_page_enable, .perf_counter_user_enable,
        .fx_save_restore_enable, .simd_fp_exc_enable, .ext_state_save_enable,
        .fault_address, .table_base, .pf_valid, .pf_addr, .cpl, .ts_read_req,
        .ts_allow, .dbg_access, .dbg_reg_num, .dbg_ud, .dbg_target,
        .io_bp_enable, .pde_page_size, .large_page_sel, .large_page_reject,
        .redir_bitmap_bit, .v86_virt_int, .swint_redirect, .pm_virt_sti_cli);

    always #20 clk = ~clk;

    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction : xs

    task print_verdict();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    task chk_bit(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    task chk_word(input string n, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word

    // an idle edge first, so a release and a new request never collide
    task xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
              input logic [3:0] b);
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= b;
        read <= rd;
        write <= ~rd;
        do @(posedge clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        logic [31:0] m;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & FC_RW_MASK;
        xfer(1'b0, a, d, b);
        if (a == OFS_FC_LO) begin
            fc_m = (fc_m & ~m) | (d & m);
        end
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(1'b1, a, 32'h0000_0000, 4'hF);
    endtask : rd

    task chk_outs();
        @(negedge clk);
        chk_bit("v86_ext_enable", fc_m[BIT_V86], v86_ext_enable);
        chk_bit("pm_virt_int_enable", fc_m[BIT_PVI], pm_virt_int_enable);
        chk_bit("ts_restrict", fc_m[BIT_TSR], timestamp_priv_restrict);
        chk_bit("debug_ext_enable", fc_m[BIT_DBG], debug_ext_enable);
        chk_bit("io_bp_enable", fc_m[BIT_DBG], io_bp_enable);
        chk_bit("large_page_enable", fc_m[BIT_LPG] & ~fc_m[BIT_PAE],
                large_page_enable);
        chk_bit("phys_addr_ext", fc_m[BIT_PAE], phys_addr_ext_enable);
        chk_bit("mce", fc_m[BIT_MCE], machine_check_enable);
        chk_bit("gpg", fc_m[BIT_GPG], global_page_enable);
        chk_bit("pcu", fc_m[BIT_PCU], perf_counter_user_enable);
        chk_bit("fxs", fc_m[BIT_FXS], fx_save_restore_enable);
        chk_bit("sfe", fc_m[BIT_SFE], simd_fp_exc_enable);
        chk_bit("xsv", fc_m[BIT_XSV], ext_state_save_enable);
    endtask : chk_outs

    // read data are judged at the edge that completes the read
    always @(posedge clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("wrong value read count expected 0 seen 1");
            end else begin
                chk_word("readdata", exp_q.pop_front(), readdata);
            end
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i]) rd(regs[i], 32'h0000_0000);
        chk_outs();
        wr(OFS_FC_LO, 32'hFFFF_FFFF, 4'hF);
        rd(OFS_FC_LO, fc_m);
        chk_outs();
        repeat (12) begin
            wr(OFS_FC_LO, xs(), 4'(xs()));
            rd(OFS_FC_LO, fc_m);
            chk_outs();
        end
        wr(8'h30, xs(), 4'hF);
        rd(8'h30, 32'h0000_0000);
        wr(OFS_MODE, 32'hFFFF_FFFF, 4'hF);
        rd(OFS_MODE, MODE_MASK);
        // upper write fault only in 64-bit mode
        wr(OFS_IRQ_MASK, 32'h0000_000F, 4'hF);
        wr(OFS_MODE, 32'h0000_0000, 4'hF);
        wr(OFS_FC_HI, 32'h0000_0001, 4'hF);
        rd(OFS_IRQ_STAT, 32'h0000_0000);
        wr(OFS_MODE, (32'h1 << MODE_CODE64) | (32'h1 << MODE_LONG), 4'hF);
        wr(OFS_FC_HI, 32'h8000_0000, 4'hF);
        @(negedge clk);
        chk_bit("irq", 1'b1, irq);
        rd(OFS_FC_HI, 32'h0000_0000);
        rd(OFS_IRQ_STAT, 32'h1 << EV_GP);
        rd(OFS_IRQ_STAT, 32'h0000_0000);
        chk_bit("irq", 1'b0, irq);
        wr(OFS_MODE, 32'h0000_0000, 4'hF);
        // timestamp privilege, denial masked from irq
        wr(OFS_IRQ_MASK, 32'h0000_0000, 4'hF);
        for (int t = 0; t < 2; t++) begin
            wr(OFS_FC_LO, t << BIT_TSR, 4'hF);
            for (int c = 0; c < 4; c++) begin
                @(posedge clk);
                cpl <= 2'(c);
                ts_read_req <= 1'b1;
                @(negedge clk);
                chk_bit("ts_allow", t == 0 || c == 0, ts_allow);
            end
            @(posedge clk);
            ts_read_req <= 1'b0;
            @(negedge clk);
            chk_bit("irq", 1'b0, irq);
            rd(OFS_IRQ_STAT, t ? (32'h1 << EV_TS) : 32'h0000_0000);
        end
        wr(OFS_IRQ_MASK, 32'h0000_000F, 4'hF);
        for (int de = 0; de < 2; de++) begin
            wr(OFS_FC_LO, de << BIT_DBG, 4'hF);
            for (int n = 0; n < 8; n++) begin
                @(posedge clk);
                dbg_reg_num <= 3'(n);
                dbg_access <= 1'b1;
                @(negedge clk);
                chk_bit("dbg_ud", de && (n == 4 || n == 5), dbg_ud);
                if (!(de && (n == 4 || n == 5))) begin
                    chk_word("dbg_target", (!de && n == 4) ? 6 :
                        (!de && n == 5) ? 7 : n, dbg_target);
                end
            end
            @(posedge clk);
            dbg_access <= 1'b0;
            @(negedge clk);
            chk_bit("irq", de, irq);
            rd(OFS_IRQ_STAT, de ? (32'h1 << EV_UD) : 32'h0000_0000);
        end
        for (int p = 0; p < 4; p++) begin
            wr(OFS_FC_LO, p << BIT_LPG, 4'hF);
            chk_outs();
            for (int s = 0; s < 2; s++) begin
                @(posedge clk);
                pde_page_size <= s[0];
                @(negedge clk);
                chk_bit("large_page_sel", s && p != 0, large_page_sel);
                chk_bit("large_reject", s && p == 0, large_page_reject);
            end
        end
        for (int m = 0; m < 8; m++) begin
            wr(OFS_MODE, m, 4'hF);
            for (int f = 0; f < 4; f++) begin
                wr(OFS_FC_LO, f, 4'hF);
                for (int bm = 0; bm < 2; bm++) begin
                    @(posedge clk);
                    redir_bitmap_bit <= bm[0];
                    @(negedge clk);
                    chk_bit("swint_redirect", f[0] && m[2] && !bm,
                            swint_redirect);
                    chk_bit("pm_sti_cli", f[1] && !m[2],
                            pm_virt_sti_cli);
                    chk_bit("v86_virt_int", f[0] && m[2],
                            v86_virt_int);
                end
            end
        end
        a64 = {xs(), xs()};
        @(posedge clk);
        pf_addr <= a64;
        pf_valid <= 1'b1;
        @(posedge clk);
        pf_valid <= 1'b0;
        pf_addr <= ~a64;
        @(negedge clk);
        chk_word("fault_address", a64, fault_address);
        rd(OFS_FA_LO, a64[31:0]);
        rd(OFS_FA_HI, a64[63:32]);
        rd(OFS_IRQ_STAT, 32'h1 << EV_PF);
        a64 = {xs(), xs()};
        wr(OFS_TB_LO, a64[31:0], 4'hF);
        wr(OFS_TB_HI, a64[63:32], 4'hF);
        @(negedge clk);
        chk_word("table_base", a64, table_base);
        rd(OFS_TB_LO, a64[31:0]);
        rd(OFS_TB_HI, a64[63:32]);
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule : paging_feature_control_regs_test
